// *** src/pll_latch_pkg.sv ***
// Purpose: Constants for the dual synthesizer serial latch bank
// Assumes: 22-bit control words, two select bits in the low positions
// Notes: Word field positions used by the bank; the bench hardcodes its own
package pll_latch_pkg;
  localparam int WORD_W = 22;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  // Latch select codes
  localparam logic [1:0] SEL_IF_REF = 2'h0;
  localparam logic [1:0] SEL_IF_FB = 2'h1;
  localparam logic [1:0] SEL_RF_REF = 2'h2;
  localparam logic [1:0] SEL_RF_FB = 2'h3;
  // Reference latch fields
  localparam int REF_DIV_LSB = 2;
  localparam int REF_DIV_W = 14;
  localparam int REF_SENSE_BIT = 17;
  localparam int REF_GAIN_BIT = 18;
  localparam int REF_TRISTATE_BIT = 19;
  localparam int REF_LOCK_SEL_BIT = 20;
  localparam int REF_FASTLOCK_SEL_BIT = 21;
  // Feedback latch fields
  localparam int FB_A_LSB = 2;
  localparam int FB_A_W = 6;
  localparam int FB_B_LSB = 9;
  localparam int FB_B_W = 11;
  localparam int FB_PRESCALER_BIT = 20;
  localparam int FB_POWERDOWN_BIT = 21;
  // Power-up contents of every latch
  localparam logic [21:0] WORD_RESET = 22'h000000;
  // Cycles the pump stays tri-stated before a synchronous power-down completes
  localparam logic [1:0] PD_SETTLE_CYCLES = 2'h2;
endpackage : pll_latch_pkg

// *** src/dual_pll_latch_bank.sv ***
// Purpose: Serial control-word bank of a dual IF/RF synthesizer
// Assumes: Link clock, data and strobe are asynchronous to i_clk
// Notes: Link inputs are double-registered, then edge-detected
//
// Functional notes
// - 22-bit shift register, MSB first, rising clock
// - Strobe rising edge copies word to selected latch
// - Code 00 loads IF reference latch, 14-bit
// - Code 01 loads IF feedback latch
// - Code 10 loads RF reference latch, 14-bit
// - Feedback latch holds 6-bit A, 11-bit B
// - IF reference latch bit layout
// - IF feedback latch bit layout
// - RF reference latch mirrors IF layout
// - Code 11 loads RF feedback latch, layout
// - IF sense bit selects detector polarity
// - IF tri-state bit floats charge pump
// - IF gain bit picks pump current
// - IF prescaler bit picks 8/9 or 16/17
// - Prescaler encodings per side
// - RF sense bit selects detector polarity
// - Per-side power-down bit shuts section
// - Tri-stated pump means immediate power-down
module dual_pll_latch_bank (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Three-wire link
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  input wire logic i_load_strobe,
  // IF reference fields
  output logic [13:0] o_if_ref_div,
  output logic o_if_detector_sense_bit,
  output logic o_if_pump_tristate_bit,
  output logic o_if_pump_gain_bit,
  output logic o_if_lock_detect_select,
  output logic o_if_fastlock_output_select,
  // IF feedback fields
  output logic [5:0] o_if_a_count,
  output logic [10:0] o_if_b_count,
  output logic o_if_prescaler_select,
  output logic o_if_powerdown_bit,
  // RF reference fields
  output logic [13:0] o_rf_ref_div,
  output logic o_rf_detector_sense_bit,
  output logic o_rf_pump_tristate_bit,
  output logic o_rf_pump_gain_bit,
  output logic o_rf_lock_detect_select,
  output logic o_rf_fastlock_output_select,
  // RF feedback fields
  output logic [5:0] o_rf_a_count,
  output logic [10:0] o_rf_b_count,
  output logic o_rf_prescaler_select,
  output logic o_rf_powerdown_bit,
  // Section control
  output logic o_if_pump_hiz,
  output logic o_if_section_off,
  output logic o_rf_pump_hiz,
  output logic o_rf_section_off
);

  // ==========================================================
  // Input synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync1_d;
  logic [2:0] sync2_q;
  logic [2:0] sync2_d;
  logic [2:0] sync3_q;
  logic [2:0] sync3_d;

  // Pin order in every stage: strobe, data, clock
  always_comb
  begin
    sync1_d = {i_load_strobe, i_serial_data, i_serial_clk};
    sync2_d = sync1_q;
    sync3_d = sync2_q;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
    end
  end

  // ==========================================================
  // Link edge detection
  logic sclk_rise;
  logic strobe_rise;
  logic data_bit;

  // Third stage only delays, so data lines up with its clock edge
  assign sclk_rise = sync2_q[0] & ~sync3_q[0];
  assign strobe_rise = sync2_q[2] & ~sync3_q[2];
  assign data_bit = sync3_q[1];

  // ==========================================================
  // Field decoding
  function automatic logic field_bit(input logic [21:0] w, input int pos);
    field_bit = w[pos];
  endfunction

  function automatic logic [1:0] select_of(input logic [21:0] w);
    select_of = w[pll_latch_pkg::SEL_LSB +: pll_latch_pkg::SEL_W];
  endfunction

  function automatic logic [13:0] ref_div_of(input logic [21:0] w);
    ref_div_of = w[pll_latch_pkg::REF_DIV_LSB +: pll_latch_pkg::REF_DIV_W];
  endfunction

  function automatic logic [5:0] a_count_of(input logic [21:0] w);
    a_count_of = w[pll_latch_pkg::FB_A_LSB +: pll_latch_pkg::FB_A_W];
  endfunction

  function automatic logic [10:0] b_count_of(input logic [21:0] w);
    b_count_of = w[pll_latch_pkg::FB_B_LSB +: pll_latch_pkg::FB_B_W];
  endfunction

  // ==========================================================
  // Input shift register
  logic [21:0] shift_q;
  logic [21:0] shift_d;

  always_comb
  begin
    shift_d = shift_q;
    if (sclk_rise)
    begin
      shift_d = {shift_q[20:0], data_bit};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      shift_q <= pll_latch_pkg::WORD_RESET;
    end
    else
    begin
      shift_q <= shift_d;
    end
  end

  // ==========================================================
  // Control latches, indexed by select code
  logic [21:0] word_q [4];
  logic [21:0] word_d [4];
  logic [1:0] load_code;

  assign load_code = select_of(shift_q);

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      word_d[i] = word_q[i];
      if (strobe_rise && (load_code == 2'(i)))
      begin
        word_d[i] = shift_q;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        word_q[i] <= pll_latch_pkg::WORD_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        word_q[i] <= word_d[i];
      end
    end
  end

  // ==========================================================
  // Latch contents by function
  logic [21:0] if_ref_word;
  logic [21:0] if_fb_word;
  logic [21:0] rf_ref_word;
  logic [21:0] rf_fb_word;

  assign if_ref_word = word_q[pll_latch_pkg::SEL_IF_REF];
  assign if_fb_word = word_q[pll_latch_pkg::SEL_IF_FB];
  assign rf_ref_word = word_q[pll_latch_pkg::SEL_RF_REF];
  assign rf_fb_word = word_q[pll_latch_pkg::SEL_RF_FB];

  // ==========================================================
  // Power-down sequencing, side 0 IF, side 1 RF
  generate
    for (genvar s = 0; s < 2; s++)
    begin : g_side
      logic pd_req;
      logic ts_req;
      logic [1:0] pd_cnt_q;
      logic [1:0] pd_cnt_d;
      logic off_q;
      logic off_d;
      logic hiz_q;
      logic hiz_d;

      assign pd_req = field_bit(word_q[2*s+1], pll_latch_pkg::FB_POWERDOWN_BIT);
      assign ts_req = field_bit(word_q[2*s], pll_latch_pkg::REF_TRISTATE_BIT);

      always_comb
      begin
        pd_cnt_d = pd_cnt_q;
        off_d = off_q;
        hiz_d = ts_req;
        if (!pd_req)
        begin
          pd_cnt_d = 2'h0;
          off_d = 1'h0;
        end
        else if (ts_req)
        begin
          off_d = 1'h1;
        end
        else
        begin
          hiz_d = 1'h1;
          if (pd_cnt_q == pll_latch_pkg::PD_SETTLE_CYCLES)
          begin
            off_d = 1'h1;
          end
          else
          begin
            pd_cnt_d = pd_cnt_q + 2'h1;
          end
        end
      end

      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          pd_cnt_q <= 2'h0;
          off_q <= 1'h0;
          hiz_q <= 1'h0;
        end
        else
        begin
          pd_cnt_q <= pd_cnt_d;
          off_q <= off_d;
          hiz_q <= hiz_d;
        end
      end
    end
  endgenerate

  // ==========================================================
  // IF reference fields
  assign o_if_ref_div = ref_div_of(if_ref_word);
  assign o_if_detector_sense_bit = field_bit(if_ref_word, pll_latch_pkg::REF_SENSE_BIT);
  assign o_if_pump_tristate_bit = field_bit(if_ref_word, pll_latch_pkg::REF_TRISTATE_BIT);
  assign o_if_pump_gain_bit = field_bit(if_ref_word, pll_latch_pkg::REF_GAIN_BIT);
  assign o_if_lock_detect_select = field_bit(if_ref_word, pll_latch_pkg::REF_LOCK_SEL_BIT);
  assign o_if_fastlock_output_select =
    field_bit(if_ref_word, pll_latch_pkg::REF_FASTLOCK_SEL_BIT);

  // IF feedback fields
  assign o_if_a_count = a_count_of(if_fb_word);
  assign o_if_b_count = b_count_of(if_fb_word);
  assign o_if_prescaler_select =
    field_bit(if_fb_word, pll_latch_pkg::FB_PRESCALER_BIT);
  assign o_if_powerdown_bit = field_bit(if_fb_word, pll_latch_pkg::FB_POWERDOWN_BIT);

  // RF reference fields
  assign o_rf_ref_div = ref_div_of(rf_ref_word);
  assign o_rf_detector_sense_bit = field_bit(rf_ref_word, pll_latch_pkg::REF_SENSE_BIT);
  assign o_rf_pump_tristate_bit = field_bit(rf_ref_word, pll_latch_pkg::REF_TRISTATE_BIT);
  assign o_rf_pump_gain_bit = field_bit(rf_ref_word, pll_latch_pkg::REF_GAIN_BIT);
  assign o_rf_lock_detect_select = field_bit(rf_ref_word, pll_latch_pkg::REF_LOCK_SEL_BIT);
  assign o_rf_fastlock_output_select =
    field_bit(rf_ref_word, pll_latch_pkg::REF_FASTLOCK_SEL_BIT);

  // RF feedback fields
  assign o_rf_a_count = a_count_of(rf_fb_word);
  assign o_rf_b_count = b_count_of(rf_fb_word);
  assign o_rf_prescaler_select = field_bit(rf_fb_word, pll_latch_pkg::FB_PRESCALER_BIT);
  assign o_rf_powerdown_bit = field_bit(rf_fb_word, pll_latch_pkg::FB_POWERDOWN_BIT);

  // ==========================================================
  // Section control
  assign o_if_pump_hiz = g_side[0].hiz_q;
  assign o_if_section_off = g_side[0].off_q;
  assign o_rf_pump_hiz = g_side[1].hiz_q;
  assign o_rf_section_off = g_side[1].off_q;

endmodule // dual_pll_latch_bank

// *** verification/dual_pll_latch_bank_properties.sv ***
// Purpose: Port assertions for the latch bank
// Assumes: Strobe stays high for several clocks
// Notes: Bound to every bank instance
module dual_pll_latch_bank_checker (
  // Clock, reset, strobe
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load_strobe,
  // Latch fields
  input wire logic [13:0] o_if_ref_div,
  input wire logic [10:0] o_if_b_count,
  input wire logic [5:0] o_rf_a_count,
  input wire logic o_if_pump_tristate_bit,
  input wire logic o_rf_pump_tristate_bit,
  input wire logic o_if_powerdown_bit,
  input wire logic o_rf_powerdown_bit,
  // Section control
  input wire logic o_if_pump_hiz,
  input wire logic o_if_section_off,
  input wire logic o_rf_pump_hiz,
  input wire logic o_rf_section_off
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========
  // Checks
  pump_float_a: assert property (o_if_pump_tristate_bit |=> o_if_pump_hiz)
    else $error("IF pump not floated");
  async_down_a: assert property ($rose(o_if_powerdown_bit) && o_if_pump_tristate_bit
    |=> o_if_section_off) else $error("IF power-down late");
  sync_down_a: assert property ($rose(o_rf_powerdown_bit) && !o_rf_pump_tristate_bit
    |=> o_rf_pump_hiz && !o_rf_section_off ##3 o_rf_section_off) else $error("RF sequence");
  power_up_a: assert property ($fell(o_if_powerdown_bit) |=> !o_if_section_off)
    else $error("IF not restored");
  off_cause_a: assert property ($rose(o_rf_section_off) |-> o_rf_powerdown_bit)
    else $error("RF off without bit");
  ref_hold_a: assert property ($changed(o_if_ref_div) |-> $past(i_load_strobe))
    else $error("IF divider moved");
  b_hold_a: assert property ($changed(o_if_b_count) |-> $past(i_load_strobe))
    else $error("IF B count moved");
  a_hold_a: assert property ($changed(o_rf_a_count) |-> $past(i_load_strobe))
    else $error("RF A count moved");
endmodule // dual_pll_latch_bank_checker
bind dual_pll_latch_bank dual_pll_latch_bank_checker i_checker (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_load_strobe(i_load_strobe),
  .o_if_ref_div(o_if_ref_div),
  .o_if_b_count(o_if_b_count),
  .o_rf_a_count(o_rf_a_count),
  .o_if_pump_tristate_bit(o_if_pump_tristate_bit),
  .o_rf_pump_tristate_bit(o_rf_pump_tristate_bit),
  .o_if_powerdown_bit(o_if_powerdown_bit),
  .o_rf_powerdown_bit(o_rf_powerdown_bit),
  .o_if_pump_hiz(o_if_pump_hiz),
  .o_if_section_off(o_if_section_off),
  .o_rf_pump_hiz(o_rf_pump_hiz),
  .o_rf_section_off(o_rf_section_off)
);

// *** verification/host_link_model.sv ***
// Purpose: Host side of the three-wire link
// Assumes: Link half period of 6 clocks
// Notes: Clock idles low between frames
module host_link_model (
  // Clock
  input wire logic i_clk,
  // Link
  output logic o_serial_clk = 1'h0,
  output logic o_serial_data = 1'h0,
  output logic o_load_strobe = 1'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic half();
    repeat (6) @(posedge i_clk);
    #1;
  endtask
  task automatic send(input logic [21:0] w, input logic ld);
    for (int i = 21; i >= 0; i--)
    begin
      o_serial_data = w[i];
      half();
      o_serial_clk = 1'h1;
      half();
      o_serial_clk = 1'h0;
    end
    o_serial_data = ~w[0];
    o_load_strobe = ld;
    repeat (4) half();
    o_load_strobe = 1'h0;
    half();
  endtask
endmodule // host_link_model

// *** verification/test_dual_pll_latch_bank.sv ***
// Purpose: Self-checking bench for the latch bank
// Assumes: Host model drives the link
// Notes: All four latches read back after each word
module test_dual_pll_latch_bank;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Signals
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic i_serial_clk, i_serial_data, i_load_strobe;
  logic [13:0] o_if_ref_div, o_rf_ref_div;
  logic [10:0] o_if_b_count, o_rf_b_count;
  logic [5:0] o_if_a_count, o_rf_a_count;
  logic o_if_detector_sense_bit, o_if_pump_tristate_bit, o_if_pump_gain_bit;
  logic o_if_lock_detect_select, o_if_fastlock_output_select, o_if_prescaler_select;
  logic o_rf_detector_sense_bit, o_rf_pump_tristate_bit, o_rf_pump_gain_bit;
  logic o_rf_lock_detect_select, o_rf_fastlock_output_select, o_rf_prescaler_select;
  logic o_if_powerdown_bit, o_rf_powerdown_bit, o_if_pump_hiz, o_rf_pump_hiz;
  logic o_if_section_off, o_rf_section_off;
  logic [21:0] ex [4];
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  always #2 i_clk = ~i_clk;
  dual_pll_latch_bank i_dual_pll_latch_bank (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_serial_clk(i_serial_clk),
    .i_serial_data(i_serial_data),
    .i_load_strobe(i_load_strobe),
    .o_if_ref_div(o_if_ref_div),
    .o_if_detector_sense_bit(o_if_detector_sense_bit),
    .o_if_pump_tristate_bit(o_if_pump_tristate_bit),
    .o_if_pump_gain_bit(o_if_pump_gain_bit),
    .o_if_lock_detect_select(o_if_lock_detect_select),
    .o_if_fastlock_output_select(o_if_fastlock_output_select),
    .o_if_a_count(o_if_a_count),
    .o_if_b_count(o_if_b_count),
    .o_if_prescaler_select(o_if_prescaler_select),
    .o_if_powerdown_bit(o_if_powerdown_bit),
    .o_rf_ref_div(o_rf_ref_div),
    .o_rf_detector_sense_bit(o_rf_detector_sense_bit),
    .o_rf_pump_tristate_bit(o_rf_pump_tristate_bit),
    .o_rf_pump_gain_bit(o_rf_pump_gain_bit),
    .o_rf_lock_detect_select(o_rf_lock_detect_select),
    .o_rf_fastlock_output_select(o_rf_fastlock_output_select),
    .o_rf_a_count(o_rf_a_count),
    .o_rf_b_count(o_rf_b_count),
    .o_rf_prescaler_select(o_rf_prescaler_select),
    .o_rf_powerdown_bit(o_rf_powerdown_bit),
    .o_if_pump_hiz(o_if_pump_hiz),
    .o_if_section_off(o_if_section_off),
    .o_rf_pump_hiz(o_rf_pump_hiz),
    .o_rf_section_off(o_rf_section_off)
  );
  host_link_model i_host_link_model (.i_clk(i_clk), .o_serial_clk(i_serial_clk),
    .o_serial_data(i_serial_data), .o_load_strobe(i_load_strobe));
  // ==========
  // Tasks
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [21:0] rd(input int k);
    case (k)
      0: rd = {o_if_fastlock_output_select, o_if_lock_detect_select, o_if_pump_tristate_bit,
        o_if_pump_gain_bit, o_if_detector_sense_bit, 1'h0, o_if_ref_div, 2'h0};
      1: rd = {o_if_powerdown_bit, o_if_prescaler_select, o_if_b_count, 1'h0, o_if_a_count, 2'h1};
      2: rd = {o_rf_fastlock_output_select, o_rf_lock_detect_select, o_rf_pump_tristate_bit,
        o_rf_pump_gain_bit, o_rf_detector_sense_bit, 1'h0, o_rf_ref_div, 2'h2};
      default: rd = {o_rf_powerdown_bit, o_rf_prescaler_select, o_rf_b_count, 1'h0,
        o_rf_a_count, 2'h3};
    endcase
  endfunction
  task automatic put(input logic [21:0] w, input logic ld);
    i_host_link_model.send(w, ld);
    if (ld)
      ex[w[1:0]] = w & (w[0] ? 22'h3FFEFF : 22'h3EFFFF);
    repeat (8) @(posedge i_clk);
    #1;
    for (int k = 0; k < 4; k++)
      chk(rd(k), ex[k]);
    chk({20'h0, o_if_section_off, o_rf_section_off}, {20'h0, ex[1][21], ex[3][21]});
    chk({20'h0, o_if_pump_hiz, o_rf_pump_hiz},
      {20'h0, ex[0][19] | ex[1][21], ex[2][19] | ex[3][21]});
  endtask
  // ==========
  // Timeout
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      err_total++;
      finish_test();
    end
  end
  // ==========
  // Sequence
  initial
  begin
    for (int k = 0; k < 4; k++)
      ex[k] = 22'(k);
    repeat (8) @(posedge i_clk);
    #1;
    i_rst = 1'h0;
    repeat (3) @(posedge i_clk);
    #1;
    put(22'h3A5678, 1'h1);
    put(22'h2ABCD5, 1'h1);
    put(22'h123456, 1'h1);
    put(22'h3C0F0F, 1'h1);
    put(22'h012340, 1'h1);
    put(22'h0ABDD1, 1'h1);
    put(22'h3FFFFF, 1'h0);
    finish_test();
  end
endmodule // test_dual_pll_latch_bank
